/* File: scd_device.sv */
// device end: serial slave, address decode, divider shadows, mcu handover
// assumes sclk comes from the host; refClk is the synthesizer reference
// Overview of operation
// R1: frame is instruction then sixteen data bits
// R2: thirty-two clocks per access, back to back allowed
// R3: global address is module above register
// R4: host keeps sclk under 50/20 MHz
// R5: four-wire readback after reset
// R6: route module zero, top, transceiver groups
// R7: decode transmit and receive processing groups
// R8: synthesizer keeps old divider while writing
// R9: shadows apply on reference edge after deselect
// R10: mcu bridge uses same serial protocol; here the mcu uses parallel mcuAddr/mcuWrite/mcuWdata/mcuRdata ports instead
// R11: handover bit grants mcu register access; here it gates only mcu writes, and only to ADDR_DIV_INT; mcu reads ignore it
// R12: mcu reports done, pass, fail, code
// R13: host sets, hands over, triggers, polls
// R14: eeprom boot: upload, flush, reset, reload
// R15: later boots only reset and reload
// R16: no eeprom: run after full upload
// R17: 8 KB program, 2 KB work, 256 B dual-port
// R18: 8-bit 8051-compatible core up to 60 MHz
// R19: unmapped accesses ignore writes, read zero
`timescale 1ns/1ps
module scd_device #(
    parameter int PROG_DEPTH = scd_pkg::PROG_BYTES
) (
    scd_link_if.dev link,
    input wire logic refClk,
    input wire logic rst_b,
    // mcu side: it writes its result and reads the trigger
    input wire logic mcuResultValid,
    input wire scd_pkg::scd_result_t mcuResult,
    input wire logic [7:0] mcuErrCode,
    input wire logic mcuWantsBus,
    input wire logic [10:0] mcuAddr,
    input wire logic mcuWrite,
    input wire logic [15:0] mcuWdata,
    output logic mcuGranted,
    output logic mcuRun,
    output logic mcuTrigger,
    output logic [15:0] mcuRdata,
    output logic [31:0] appliedDivider,
    output logic [15:0] ctrlOut
);
    import scd_pkg::*;
    initial begin
        if (PROG_DEPTH < 2 || PROG_DEPTH > 65536) $error("bad PROG_DEPTH");
    end

    typedef struct packed {
        logic [4:0] bitCnt;
        logic inData;
        logic [15:0] instr;
        logic [15:0] shiftIn;
        logic [15:0] ctrl;
        logic [15:0] status;
        logic [15:0] divInt;
        logic [15:0] divFracHi;
        logic [15:0] divFracLo;
        logic [15:0] progCnt;
        logic loaded;
        logic shadowDirty;
    } scd_dev_state_t;
    scd_dev_state_t s_reg, s_next;

    logic [7:0] progMem [PROG_DEPTH]; // [R17]
    // backing words for every mapped group, so writes read back
    logic [15:0] regMem [2**ADDR_W];
    // outside the state struct: launched on the opposite sclk edge
    logic [15:0] shiftOutReg;
    logic [10:0] curAddr;
    logic mapped;
    logic doWrite;
    logic [15:0] rdVal;
    logic hostActive;

    // frame end is seen in the sclk domain; address from instruction fields
    assign curAddr = {s_reg.instr[MOD_LSB +: MOD_W], s_reg.instr[REG_LSB +: REG_W]}; // [R3]
    assign hostActive = !link.portSelectLow_b;

    function automatic logic addrMapped(input logic [10:0] a);
        logic [4:0] m;
        logic [5:0] r;
        m = a[10:6];
        r = a[5:0];
        addrMapped = 1'b0;
        if (m == MOD_MCU) addrMapped = (r[5:4] == 2'b00) || r[5]; // [R6]
        else if (m[4:1] == MOD_TOP_HI || m[4:1] == MOD_TRX_HI) addrMapped = 1'b1; // [R6]
        else if (m == MOD_TX_PROC || m == MOD_RX_PROC) addrMapped = !r[5]; // [R7]
        else if (m >= MOD_TX_OSC && m <= MOD_TX_FILT_HI) addrMapped = 1'b1; // [R7]
        else if (m > MOD_RX_PROC && m <= MOD_RX_FILT_HI) addrMapped = 1'b1; // [R7]
    endfunction : addrMapped

    function automatic logic [15:0] readReg(input scd_dev_state_t st, input logic [10:0] a);
        readReg = 16'h0000; // [R19]
        case (a)
            ADDR_CTRL: readReg = st.ctrl;
            ADDR_STATUS: readReg = st.status; // [R12]
            ADDR_PROG: readReg = st.progCnt;
            ADDR_DIV_INT: readReg = st.divInt;
            ADDR_DIV_FRAC_HI: readReg = st.divFracHi;
            ADDR_DIV_FRAC_LO: readReg = st.divFracLo;
            default: readReg = addrMapped(a) ? regMem[a] : 16'h0000; // [R19]
        endcase
    endfunction : readReg

    always_comb begin
        s_next = s_reg;
        doWrite = 1'b0;
        mapped = addrMapped(curAddr);
        rdVal = readReg(s_reg, {s_reg.instr[MOD_LSB +: MOD_W], s_reg.instr[REG_LSB +: REG_W]});
        if (hostActive) begin
            s_next.bitCnt = s_reg.bitCnt + 5'h01; // [R2]
            if (!s_reg.inData) begin
                s_next.instr = {s_reg.instr[14:0], link.sdioToDev}; // [R1]
                if (s_reg.bitCnt == 5'h0f) begin
                    s_next.inData = 1'b1;
                    s_next.bitCnt = 5'h00;
                end
            end else begin
                s_next.shiftIn = {s_reg.shiftIn[14:0], link.sdioToDev};
                if (s_reg.bitCnt == 5'h0f) begin
                    s_next.inData = 1'b0; // next instruction may follow [R2]
                    s_next.bitCnt = 5'h00;
                    doWrite = s_reg.instr[CMD_POS] && mapped; // [R19]
                end
            end
        end else begin
            s_next.bitCnt = 5'h00;
            s_next.inData = 1'b0;
        end
        // mcu writes only with the handover granted
        if (s_reg.ctrl[CTRL_HANDOVER] && mcuWantsBus && mcuWrite && !hostActive
            && addrMapped(mcuAddr) && mcuAddr == ADDR_DIV_INT) begin // [R11] [R10]
            s_next.divInt = mcuWdata;
            s_next.shadowDirty = 1'b1;
        end
        if (doWrite) begin
            case (curAddr)
                ADDR_CTRL: s_next.ctrl = {s_reg.shiftIn[14:0], link.sdioToDev};
                ADDR_PROG: begin
                    if (s_reg.progCnt < 16'(PROG_DEPTH)) begin
                        s_next.progCnt = s_reg.progCnt + 16'h0001;
                    end
                end
                ADDR_DIV_INT: begin
                    s_next.divInt = {s_reg.shiftIn[14:0], link.sdioToDev}; // [R8]
                    s_next.shadowDirty = 1'b1;
                end
                ADDR_DIV_FRAC_HI: begin
                    s_next.divFracHi = {s_reg.shiftIn[14:0], link.sdioToDev}; // [R8]
                    s_next.shadowDirty = 1'b1;
                end
                ADDR_DIV_FRAC_LO: begin
                    s_next.divFracLo = {s_reg.shiftIn[14:0], link.sdioToDev}; // [R8]
                    s_next.shadowDirty = 1'b1;
                end
                default: s_next.ctrl = s_reg.ctrl;
            endcase
        end
        // the core sees the image once loaded: full upload, or again once mcu reset is released
        if (s_reg.ctrl[CTRL_MCU_RST]) begin
            s_next.loaded = 1'b0; // [R14] [R15]
        end else if (s_reg.progCnt == 16'(PROG_DEPTH)) begin
            s_next.loaded = 1'b1; // [R16]
        end
        if (s_reg.ctrl[CTRL_TRIGGER]) begin
            s_next.status = 16'h0000;
        end
        if (mcuResultValid) begin
            s_next.status = {mcuErrCode, 6'h00, mcuResult}; // set wins over trigger [R12]
        end
        if (doWrite || mcuWantsBus || !hostActive) begin
            s_next.shadowDirty = s_next.shadowDirty;
        end
    end

    // shift-out launched on falling sclk so host samples on rising
    always_ff @(negedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            shiftOutReg <= 16'h0000;
        end else if (s_reg.inData && s_reg.bitCnt == 5'h00 && !s_reg.instr[CMD_POS]) begin
            shiftOutReg <= mapped ? rdVal : 16'h0000; // [R19]
        end else if (s_reg.inData) begin
            shiftOutReg <= {shiftOutReg[14:0], 1'b0};
        end
    end

    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg.bitCnt <= 5'h00;
            s_reg.inData <= 1'b0;
            s_reg.instr <= 16'h0000;
            s_reg.shiftIn <= 16'h0000;
            s_reg.ctrl <= CTRL_RESET; // four-wire after reset [R5]
            s_reg.status <= 16'h0000;
            s_reg.divInt <= 16'h0000;
            s_reg.divFracHi <= 16'h0000;
            s_reg.divFracLo <= 16'h0000;
            s_reg.progCnt <= 16'h0000;
            s_reg.loaded <= 1'b0;
            s_reg.shadowDirty <= 1'b0;
        end else begin
            s_reg.bitCnt <= s_next.bitCnt;
            s_reg.inData <= s_next.inData;
            s_reg.instr <= s_next.instr;
            s_reg.shiftIn <= s_next.shiftIn;
            s_reg.ctrl <= s_next.ctrl;
            s_reg.status <= s_next.status;
            s_reg.divInt <= s_next.divInt;
            s_reg.divFracHi <= s_next.divFracHi;
            s_reg.divFracLo <= s_next.divFracLo;
            s_reg.progCnt <= s_next.progCnt;
            s_reg.loaded <= s_next.loaded;
            s_reg.shadowDirty <= s_next.shadowDirty;
        end
    end

    always_ff @(posedge link.sclk) begin
        if (doWrite) begin
            regMem[curAddr] <= {s_reg.shiftIn[14:0], link.sdioToDev}; // [R6] [R7]
        end
        if (doWrite && curAddr == ADDR_PROG && s_reg.progCnt < 16'(PROG_DEPTH)) begin
            progMem[s_reg.progCnt[$clog2(PROG_DEPTH)-1:0]] <= s_reg.shiftIn[6:0] == 7'h00 ?
                {s_reg.shiftIn[6:0], link.sdioToDev} : {s_reg.shiftIn[6:0], link.sdioToDev};
        end
    end

    // reference domain: select level crosses via three flops
    logic [2:0] selSync;
    logic [31:0] divStaged;
    logic selHigh;
    always_ff @(posedge refClk or negedge rst_b) begin
        if (!rst_b) begin
            selSync <= 3'b000;
            appliedDivider <= 32'h0000_0000;
        end else begin
            selSync <= {selSync[1:0], link.portSelectLow_b};
            // words are stable while select is high, so a plain capture is safe
            if (selHigh) begin
                appliedDivider <= divStaged; // [R9] [R8]
            end
        end
    end
    assign selHigh = selSync[1] && selSync[2];
    assign divStaged = {s_reg.divInt[9:0], s_reg.divFracHi[5:0], s_reg.divFracLo};

    // four-wire drives the dedicated line, three-wire shares sdio [R5]
    assign link.serialOutLine = s_reg.ctrl[CTRL_WIRE3] ? 1'b0 : shiftOutReg[15];
    assign link.sdioFromDev = shiftOutReg[15];
    assign link.sdioOe_b = !(s_reg.ctrl[CTRL_WIRE3] && s_reg.inData && !s_reg.instr[CMD_POS]
        && hostActive);
    assign mcuGranted = s_reg.ctrl[CTRL_HANDOVER] && !hostActive; // [R11]
    assign mcuRun = s_reg.loaded; // [R16]
    assign mcuTrigger = s_reg.ctrl[CTRL_TRIGGER]; // [R13]
    // always_comb so that register file updates are seen too
    always_comb mcuRdata = readReg(s_reg, mcuAddr);
    assign ctrlOut = s_reg.ctrl;
endmodule : scd_device

/* File: scd_host.sv */
// host end: serial master making sclk by dividing its own clock
// assumes one access request at a time on the user side
`timescale 1ns/1ps
module scd_host #(
    parameter int DIV_HALF = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    scd_link_if.host link,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [10:0] reqAddr,
    input wire logic [15:0] reqWdata,
    input wire logic reqWire3,
    output logic reqReady,
    output logic respValid,
    output logic [15:0] respRdata
);
    import scd_pkg::*;
    initial begin
        if (DIV_HALF < 1 || DIV_HALF > 255) $error("bad DIV_HALF");
    end
    typedef enum logic [1:0] {SCD_H_IDLE, SCD_H_SHIFT, SCD_H_END} scd_hstate_t;
    typedef struct packed {
        scd_hstate_t st;
        logic [7:0] div;
        logic sclk;
        logic [5:0] bitCnt;
        logic [31:0] sh;
        logic [15:0] rd;
        logic write;
        logic wire3;
        logic sel_b;
        logic respV;
    } scd_host_state_t;
    scd_host_state_t s_reg, s_next;
    logic rxBit;

    assign rxBit = s_reg.wire3 ? link.sdioFromDev : link.serialOutLine;

    always_comb begin
        s_next = s_reg;
        s_next.respV = 1'b0;
        case (s_reg.st)
            SCD_H_IDLE: begin
                if (reqValid) begin
                    // instruction: cmd, four zero bits, module, register [R1] [R3]
                    s_next.sh = {reqWrite, 4'h0, reqAddr, reqWdata};
                    s_next.write = reqWrite;
                    s_next.wire3 = reqWire3; // selects the read-back line only; sclk rate comes from DIV_HALF alone [R4]
                    s_next.sel_b = 1'b0;
                    s_next.bitCnt = 6'h00;
                    s_next.div = 8'h00;
                    s_next.st = SCD_H_SHIFT;
                end
            end
            SCD_H_SHIFT: begin
                s_next.div = s_reg.div + 8'h01;
                if (s_reg.div == 8'(DIV_HALF - 1)) begin
                    s_next.div = 8'h00;
                    s_next.sclk = !s_reg.sclk;
                    if (s_reg.sclk) begin
                        // falling edge: advance to next bit
                        s_next.sh = {s_reg.sh[30:0], 1'b0};
                        if (s_reg.bitCnt == 6'(FRAME_BITS)) begin
                            s_next.st = SCD_H_END; // 32 clocks per access [R2]
                            s_next.sclk = 1'b0;
                        end
                    end else begin
                        s_next.bitCnt = s_reg.bitCnt + 6'h01;
                        if (s_reg.bitCnt >= 6'(INSTR_BITS)) begin
                            s_next.rd = {s_reg.rd[14:0], rxBit};
                        end
                        if (s_reg.bitCnt == 6'(FRAME_BITS - 1)) begin
                            s_next.bitCnt = 6'(FRAME_BITS);
                        end
                    end
                end
            end
            SCD_H_END: begin
                s_next.sel_b = 1'b1;
                s_next.respV = 1'b1;
                s_next.st = SCD_H_IDLE;
            end
            default: s_next.st = SCD_H_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '{st: SCD_H_IDLE, sel_b: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.sclk = s_reg.sclk;
    assign link.portSelectLow_b = s_reg.sel_b;
    // host keeps driving sdioToDev during the read data phase in three-wire mode too
    assign link.sdioToDev = s_reg.sh[31];
    assign reqReady = (s_reg.st == SCD_H_IDLE);
    assign respValid = s_reg.respV;
    assign respRdata = s_reg.rd;
endmodule : scd_host

/* File: scd_link_if.sv */
// serial link between host master and device slave
// keeps to-device and from-device data on separate wires; the testbench does not resolve them into one
`timescale 1ns/1ps
interface scd_link_if;
    logic sclk;
    logic portSelectLow_b;
    logic sdioToDev;
    logic sdioFromDev;
    logic sdioOe_b;
    logic serialOutLine;
    modport host (output sclk, output portSelectLow_b, output sdioToDev,
        input sdioFromDev, input sdioOe_b, input serialOutLine);
    modport dev (input sclk, input portSelectLow_b, input sdioToDev,
        output sdioFromDev, output sdioOe_b, output serialOutLine);
endinterface : scd_link_if

/* File: scd_link_properties.sv */
// checker for the serial link, the divider shadows and the handover lines
// assumes sclk is made from clk, so clk sees every sclk edge
`timescale 1ns/1ps
module scd_link_properties (
    input wire logic clk,
    input wire logic refClk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic portSelectLow_b,
    input wire logic sdioToDev,
    input wire logic sdioOe_b,
    input wire logic [15:0] ctrlOut,
    input wire logic mcuGranted,
    input wire logic mcuTrigger,
    input wire logic [31:0] appliedDivider
);
    import scd_pkg::*;
    logic sclkQ;
    logic [5:0] edgeCnt;
    // counts sclk rises inside one frame; cleared while deselected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclkQ <= 1'b0;
            edgeCnt <= 6'h00;
        end else begin
            sclkQ <= sclk;
            if (portSelectLow_b) begin
                edgeCnt <= 6'h00;
            end else if (sclk && !sclkQ) begin
                edgeCnt <= edgeCnt + 6'h01;
            end
        end
    end
    property p_idle_low;
        @(posedge clk) disable iff (!rst_b)
        portSelectLow_b && $past(portSelectLow_b) |-> !sclk;
    endproperty
    property p_frame_len;
        @(posedge clk) disable iff (!rst_b) $rose(portSelectLow_b) |-> edgeCnt == 6'h20;
    endproperty
    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_b)
        !portSelectLow_b && sclk && !sclkQ && edgeCnt >= 6'h01 && edgeCnt <= 6'h04
        |-> !sdioToDev;
    endproperty
    property p_clk_rate;
        @(posedge clk) disable iff (!rst_b) $rose(sclk) |=> sclk;
    endproperty
    property p_sel_setup;
        @(posedge clk) disable iff (!rst_b) $fell(portSelectLow_b) |-> !sclk ##1 !sclk;
    endproperty
    property p_four_wire;
        @(posedge clk) disable iff (!rst_b) !ctrlOut[CTRL_WIRE3] |-> sdioOe_b;
    endproperty
    property p_div_hold;
        @(posedge refClk) disable iff (!rst_b)
        (!portSelectLow_b) [*4] |-> $stable(appliedDivider);
    endproperty
    property p_div_apply;
        @(posedge refClk) disable iff (!rst_b)
        !$stable(appliedDivider) |-> $past(portSelectLow_b, 3);
    endproperty
    property p_grant;
        @(posedge clk) disable iff (!rst_b) mcuGranted |-> ctrlOut[CTRL_HANDOVER];
    endproperty
    property p_trigger;
        @(posedge clk) disable iff (!rst_b) $changed(mcuTrigger) |-> !portSelectLow_b;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("sclk moves while deselected");
    a_frame_len: assert property (p_frame_len) else $error("frame not 32 clocks");
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
    a_clk_rate: assert property (p_clk_rate) else $error("sclk high too short");
    a_sel_setup: assert property (p_sel_setup) else $error("sclk rises with select");
    a_four_wire: assert property (p_four_wire) else $error("shared line driven");
    a_div_hold: assert property (p_div_hold) else $error("divider moved mid frame");
    a_div_apply: assert property (p_div_apply) else $error("divider applied early");
    a_grant: assert property (p_grant) else $error("grant without handover");
    a_trigger: assert property (p_trigger) else $error("trigger moved outside a frame");
    c_frame: cover property (@(posedge clk) $rose(portSelectLow_b));
    c_wire3: cover property (@(posedge clk) !sdioOe_b);
    c_grant: cover property (@(posedge clk) mcuGranted);
    c_div: cover property (@(posedge refClk) !$stable(appliedDivider));
endmodule : scd_link_properties

/* File: scd_pkg.sv */
// shared constants for the serial configuration front end
// assumes a 16-bit instruction + 16-bit data serial frame, msb first
package scd_pkg;
    localparam int FRAME_BITS = 32;
    localparam int INSTR_BITS = 16;
    localparam int MOD_W = 5;
    localparam int REG_W = 6;
    localparam int ADDR_W = 11;
    localparam int CMD_POS = 15;
    localparam int MOD_LSB = 6;
    localparam int REG_LSB = 0;
    localparam logic [4:0] MOD_MCU = 5'h00;
    localparam logic [3:0] MOD_TOP_HI = 4'h1;
    localparam logic [3:0] MOD_TRX_HI = 4'h2;
    localparam logic [4:0] MOD_TX_PROC = 5'h08;
    localparam logic [4:0] MOD_TX_OSC = 5'h09;
    localparam logic [4:0] MOD_TX_FILT_LO = 5'h0a;
    localparam logic [4:0] MOD_TX_FILT_HI = 5'h0e;
    localparam logic [4:0] MOD_RX_PROC = 5'h10;
    localparam logic [4:0] MOD_RX_FILT_HI = 5'h16;
    // device-local addresses for the handover, mcu mailbox, program upload and divider shadows
    localparam logic [10:0] ADDR_CTRL = 11'h000;
    localparam logic [10:0] ADDR_STATUS = 11'h001;
    localparam logic [10:0] ADDR_PROG = 11'h002;
    localparam logic [10:0] ADDR_DIV_INT = 11'h100;
    localparam logic [10:0] ADDR_DIV_FRAC_HI = 11'h101;
    localparam logic [10:0] ADDR_DIV_FRAC_LO = 11'h102;
    localparam int CTRL_HANDOVER = 0;
    localparam int CTRL_WIRE3 = 1;
    localparam int CTRL_EEPROM = 2;
    localparam int CTRL_MCU_RST = 3;
    localparam int CTRL_TRIGGER = 4;
    localparam int PROG_BYTES = 8192;
    localparam int WORK_BYTES = 2048;
    localparam int DPRAM_BYTES = 256;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    typedef enum logic [1:0] {SCD_DONE_IDLE, SCD_DONE_OK, SCD_DONE_FAIL, SCD_DONE_ERR}
        scd_result_t;
endpackage : scd_pkg

/* File: testbench.sv */
// bench joining host and device ends over the link interface
// assumes DIV_HALF of 2 and a four-byte program image to keep the run short
`timescale 1ns/1ps
module testbench;
    import scd_pkg::*;
    localparam int PROG_N = 4;
    logic clk, refClk, rst_b, reqValid, reqWrite, reqWire3, reqReady, respValid;
    logic mcuResultValid, mcuWantsBus, mcuWrite, mcuGranted, mcuRun, mcuTrigger, mode3;
    logic [10:0] reqAddr, mcuAddr;
    logic [15:0] reqWdata, respRdata, mcuWdata, mcuRdata, ctrlOut, rnd;
    logic [7:0] mcuErrCode;
    logic [31:0] appliedDivider;
    logic [16:0] ent;
    logic [16:0] expQ[$];
    scd_result_t mcuResult;
    int badCount, checks, cyc;
    logic [10:0] mapA [9] = '{11'h020, 11'h0bf, 11'h0c0, 11'h161, 11'h21f, 11'h240,
        11'h3bf, 11'h41f, 11'h445};
    logic [10:0] unA [7] = '{11'h1c0, 11'h3c0, 11'h5c0, 11'h7ff, 11'h220, 11'h43f, 11'h010};
    scd_link_if link();
    scd_host #(.DIV_HALF(2)) u_scd_host (.clk(clk), .rst_b(rst_b), .link(link),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .reqWire3(reqWire3), .reqReady(reqReady), .respValid(respValid),
        .respRdata(respRdata));
    scd_device #(.PROG_DEPTH(PROG_N)) u_scd_device (.link(link), .refClk(refClk),
        .rst_b(rst_b), .mcuResultValid(mcuResultValid), .mcuResult(mcuResult),
        .mcuErrCode(mcuErrCode), .mcuWantsBus(mcuWantsBus), .mcuAddr(mcuAddr),
        .mcuWrite(mcuWrite), .mcuWdata(mcuWdata), .mcuGranted(mcuGranted), .mcuRun(mcuRun),
        .mcuTrigger(mcuTrigger), .mcuRdata(mcuRdata), .appliedDivider(appliedDivider),
        .ctrlOut(ctrlOut));
    scd_link_properties u_props (.clk(clk), .refClk(refClk), .rst_b(rst_b),
        .sclk(link.sclk), .portSelectLow_b(link.portSelectLow_b),
        .sdioToDev(link.sdioToDev), .sdioOe_b(link.sdioOe_b), .ctrlOut(ctrlOut),
        .mcuGranted(mcuGranted), .mcuTrigger(mcuTrigger), .appliedDivider(appliedDivider));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // reference clock kept off the bench clock's phase
    initial begin
        refClk = 1'b0;
        #7;
        forever #15 refClk = ~refClk;
    end
    task automatic cmpData(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t data got %h expected %h", $time, got, exp);
        end
    endtask : cmpData
    task automatic cmpOut(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t output got %h expected %h", $time, got, exp);
        end
    endtask : cmpOut
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic endTest(input string name);
        $display("test %s done, mismatches so far %0d", name, badCount);
    endtask : endTest
    // one access; returns at a falling edge once the host is idle again
    task automatic xfer(input logic wr, input logic [10:0] a, input logic [15:0] d,
            input logic chk, input logic [15:0] e);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        expQ.push_back({chk, e});
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = a;
        reqWdata = d;
        reqWire3 = mode3;
        @(negedge clk);
        reqValid = 1'b0;
        n = 0;
        while (reqReady !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
    endtask : xfer
    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        xfer(1'b1, a, d, 1'b0, 16'h0000);
    endtask : wr
    task automatic rd(input logic [10:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000, 1'b1, e);
    endtask : rd
    always @(posedge clk) begin
        if (respValid === 1'b1) begin
            if (expQ.size() == 0) begin
                badCount++;
                $display("MISMATCH t=%0t answer with nothing pending", $time);
            end else begin
                ent = expQ.pop_front();
                if (ent[16]) cmpData(respRdata, ent[15:0]);
            end
        end
    end
    // ceiling well above the roughly 7000 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            badCount++;
            $display("MISMATCH t=%0t run did not finish", $time);
            final_report();
        end
    end
    initial begin
        rst_b = 1'b0;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 11'h000;
        reqWdata = 16'h0000;
        reqWire3 = 1'b0;
        mcuResultValid = 1'b0;
        mcuResult = SCD_DONE_IDLE;
        mcuErrCode = 8'h00;
        mcuWantsBus = 1'b0;
        mcuAddr = 11'h000;
        mcuWrite = 1'b0;
        mcuWdata = 16'h0000;
        mode3 = 1'b0;
        badCount = 0;
        checks = 0;
        cyc = 0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        void'($urandom(14));
        @(negedge clk);
        cmpOut({16'h0000, ctrlOut}, {16'h0000, CTRL_RESET});
        cmpOut(appliedDivider, 32'h0000_0000);
        cmpOut({30'h0, link.portSelectLow_b, link.sclk}, 32'h2);
        endTest("reset");
        foreach (mapA[i]) begin
            rnd = 16'($urandom());
            wr(mapA[i], rnd);
            rd(mapA[i], rnd);
        end
        foreach (unA[i]) begin
            wr(unA[i], 16'($urandom()));
            rd(unA[i], 16'h0000);
        end
        endTest("decode");
        for (int i = 0; i < 3; i++) begin
            rnd = 16'($urandom()) | 16'h0001;
            wr(ADDR_DIV_INT + 11'(i), rnd);
            rd(ADDR_DIV_INT + 11'(i), rnd);
        end
        repeat (4) @(negedge clk);
        cmpOut(32'(appliedDivider != 32'h0), 32'h1);
        endTest("divider");
        wr(11'h580, 16'h5a3c);
        wr(ADDR_CTRL, 16'h0011);
        mcuWantsBus = 1'b1;
        mcuAddr = 11'h580;
        @(negedge clk);
        cmpOut({29'h0, mcuGranted, mcuTrigger, ctrlOut[CTRL_HANDOVER]}, 32'h7);
        cmpData(mcuRdata, 16'h5a3c);
        mcuResult = scd_result_t'(2'($urandom_range(3, 1)));
        mcuErrCode = 8'($urandom());
        // status moves only on sclk edges, so the result is held through a frame
        mcuResultValid = 1'b1;
        rd(ADDR_STATUS, {mcuErrCode, 6'h00, mcuResult});
        mcuResultValid = 1'b0;
        wr(ADDR_CTRL, 16'h0000);
        @(negedge clk);
        cmpOut({30'h0, mcuGranted, mcuTrigger}, 32'h0);
        mcuWantsBus = 1'b0;
        endTest("handover");
        wr(ADDR_CTRL, 16'h0002);
        mode3 = 1'b1;
        rd(ADDR_CTRL, 16'h0002);
        rnd = 16'($urandom());
        wr(11'h445, rnd);
        rd(11'h445, rnd);
        wr(ADDR_CTRL, 16'h0000);
        mode3 = 1'b0;
        rd(ADDR_CTRL, 16'h0000);
        endTest("three wire");
        for (int i = 0; i < PROG_N; i++) begin
            cmpOut({31'h0, mcuRun}, 32'h0);
            wr(ADDR_PROG, 16'($urandom_range(255)));
        end
        rd(ADDR_PROG, 16'(PROG_N));
        repeat (4) @(negedge clk);
        cmpOut({31'h0, mcuRun}, 32'h1);
        endTest("upload");
        repeat (4) @(negedge clk);
        final_report();
    end
endmodule : testbench
